/* hdl/cisb_ctrl.sv */
// Instruction-state control: fetch width, pc step, branches, state switches, exceptions
//
// Summary of operation
// - Data and fetch addresses are always full 32-bit values.
// - Compact registers 0 to 7 are the same storage as wide 0 to 7.
// - Program counter reads in compact state show bit 0 as zero.
// - Program counter writes in compact state drop bit 0.
// - Compact instructions reading the program counter see their address plus 4.
// - Status bit 5 selects wide or compact instruction state.
// - Flag clear: fetch 32-bit words, step pc by 4, decode wide.
// - Flag set: fetch 16-bit halfwords, step pc by 2, decode compact.
// - Compact instructions cannot read or write any status word.
// - Branch-exchange jumps to register; bit 0 set enters compact state.
// - Restoring saved status with flag set enters compact state.
// - Direct status writes changing the flag have no defined effect.
// - Exceptions from compact state switch to wide state at the vector.
// - Exception entry saves the flag; link suits one return sequence.
// - Undefined or trap in compact state: link is address plus 2.
// - Prefetch abort in compact state: link is fetch address plus 4.
// - Data abort in compact state: link is instruction address plus 8.
// - Interrupts in compact state: link is next address plus 4.
// - Conditional branch with 8-bit signed offset, range 256 bytes.
// - Unconditional branch with 11-bit signed offset, range 2 Kbytes.
// - Call with link is two instructions of 11-bit parts, 4 Mbytes.
// - Branch-exchange format has register select and must-be-zero field.
module cisb_ctrl
    import cisb_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                nrst,
    output logic                     fetch_req,
    output logic [31:0]              fetch_addr,
    output logic                     fetch_compact,
    input  wire logic                fetch_ack,
    input  wire logic [31:0]         fetch_data,
    output logic                     exec_valid,
    output logic [31:0]              exec_instr,
    output logic [31:0]              exec_addr,
    output logic                     exec_compact,
    output logic [31:0]              pc_read_value,
    input  wire logic                pc_wr_en,
    input  wire logic [31:0]         pc_wr_data,
    input  wire logic                status_restore,
    input  wire logic                status_wr_en,
    input  wire logic [31:0]         status_wr_data,
    input  wire logic                rf_wr_en,
    input  wire logic [3:0]          rf_wr_sel,
    input  wire logic [31:0]         rf_wr_data,
    output logic                     rf_wr_ready,
    input  wire logic [3:0]          rf_rd_sel,
    output logic [31:0]              rf_rd_data,
    input  wire logic                exc_valid,
    input  wire cisb_pkg::cisb_exc_t exc_kind,
    input  wire logic [31:0]         exc_addr,
    output logic                     exc_ack,
    output logic [31:0]              current_status_word,
    output logic [31:0]              saved_status_word,
    output logic                     compact_state
);

    typedef struct packed {
        cisb_state_t state;
        logic [31:0] pc;
        logic [31:0] status;
        logic [31:0] saved;
        logic [31:0] instr;
        logic [31:0] iaddr;
        logic        is_bx;
        logic        exec_valid;
    } cisb_regs_t;

    cisb_regs_t  r_q;
    cisb_regs_t  r_d;
    logic        ctl_wr;
    logic [3:0]  ctl_wr_sel;
    logic [31:0] ctl_wr_data;
    logic [3:0]  ctl_rd_sel;
    logic        ctl_rd;
    logic [31:0] rd_q;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic cond_pass(input logic [3:0] cond, input logic [31:0] st);
        logic n;
        logic z;
        logic c;
        logic v;
        logic res;
        n = st[FLAG_N_BIT];
        z = st[FLAG_Z_BIT];
        c = st[FLAG_C_BIT];
        v = st[FLAG_V_BIT];
        unique case (cond[3:1])
            3'h0:    res = z;
            3'h1:    res = c;
            3'h2:    res = n;
            3'h3:    res = v;
            3'h4:    res = c & ~z;
            3'h5:    res = (n == v);
            3'h6:    res = ~z & (n == v);
            default: res = 1'b1;
        endcase
        // Odd codes invert, except the always code
        if (cond[0] && cond[3:1] != 3'h7) begin
            res = ~res;
        end
        return res;
    endfunction

    // Sign extend and scale by two for halfword targets
    function automatic logic [31:0] scaled_ofs(input logic [10:0] ofs, input logic wide11);
        logic [31:0] s;
        s = wide11 ? {{21{ofs[10]}}, ofs} : {{24{ofs[7]}}, ofs[7:0]};
        return {s[30:0], 1'b0};
    endfunction

    // Compact targets keep bit 1, wide targets are word aligned
    function automatic logic [31:0] align_pc(input logic [31:0] a, input logic comp);
        logic [31:0] r;
        r = comp ? {a[31:1], 1'b0} : {a[31:2], 2'b00};
        return r;
    endfunction

    function automatic logic [31:0] link_ofs(input cisb_exc_t k, input logic comp);
        logic [31:0] o;
        unique case (k)
            EXC_UNDEF, EXC_TRAP: o = comp ? LR_OFS_2 : LR_OFS_4;
            EXC_PABORT:          o = LR_OFS_4;
            EXC_DABORT:          o = LR_OFS_8;
            EXC_IRQ, EXC_FIQ:    o = LR_OFS_4;
            default:             o = LR_OFS_4;
        endcase
        return o;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register storage

    cisb_regfile #(
        .WIDTH (32),
        .DEPTH (REG_COUNT),
        .SEL_W (REG_SEL_W)
    ) u_regs (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .wr_en     (ctl_wr | rf_wr_en),
        .wr_sel    (ctl_wr ? ctl_wr_sel : rf_wr_sel),
        .wr_data   (ctl_wr ? ctl_wr_data : rf_wr_data),
        .rd_sel    (ctl_rd ? ctl_rd_sel : rf_rd_sel),
        .rd_data_q (rd_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic        comp;
        logic [15:0] h;
        logic        take_exc;
        cisb_exc_t   kind;
        logic [31:0] eaddr;
        logic [31:0] tgt;
        comp        = r_q.status[STATE_FLAG_BIT];
        h           = r_q.instr[15:0];
        take_exc    = 1'b0;
        kind        = EXC_UNDEF;
        eaddr       = r_q.pc;
        tgt         = '0;
        r_d         = r_q;
        r_d.exec_valid = 1'b0;
        ctl_wr      = 1'b0;
        ctl_wr_sel  = LINK_REG;
        ctl_wr_data = '0;
        ctl_rd      = 1'b0;
        ctl_rd_sel  = LINK_REG;
        exc_ack     = 1'b0;
        unique case (r_q.state)
            ST_FETCH: begin
                if (exc_valid) begin
                    take_exc = 1'b1;
                    kind     = exc_kind;
                    eaddr    = exc_addr;
                    exc_ack  = 1'b1;
                end else if (status_restore) begin
                    r_d.status = r_q.saved;
                end else if (status_wr_en) begin
                    r_d.status = status_wr_data;
                end else if (pc_wr_en) begin
                    r_d.pc = align_pc(pc_wr_data, comp);
                end else if (fetch_ack) begin
                    // Compact halfword from the word lane that pc bit 1 selects
                    if (comp) begin
                        r_d.instr = {16'h0000, r_q.pc[1] ? fetch_data[31:16] : fetch_data[15:0]};
                    end else begin
                        r_d.instr = fetch_data;
                    end
                    r_d.state = ST_DECODE;
                end
            end
            ST_DECODE: begin
                r_d.state = ST_FETCH;
                r_d.is_bx = 1'b0;
                if (comp) begin
                    if (h[15:12] == OP_BCOND) begin
                        if (h[11:8] == COND_UNDEF || h[11:8] == COND_TRAP) begin
                            take_exc = 1'b1;
                            kind     = (h[11:8] == COND_TRAP) ? EXC_TRAP : EXC_UNDEF;
                        end else if (cond_pass(h[11:8], r_q.status)) begin
                            r_d.pc = r_q.pc + PC_RD_OFS_COMP + scaled_ofs({3'b000, h[7:0]}, 1'b0);
                        end else begin
                            r_d.pc = r_q.pc + STEP_COMPACT;
                        end
                    end else if (h[15:11] == OP_BUNC) begin
                        r_d.pc = r_q.pc + PC_RD_OFS_COMP + scaled_ofs(h[10:0], 1'b1);
                    end else if (h[15:11] == OP_BL_HIGH) begin
                        ctl_wr      = 1'b1;
                        ctl_wr_data = r_q.pc + PC_RD_OFS_COMP + ({{21{h[10]}}, h[10:0]} << BL_HIGH_SHIFT);
                        r_d.pc      = r_q.pc + STEP_COMPACT;
                    end else if (h[15:11] == OP_BL_LOW) begin
                        ctl_rd    = 1'b1;
                        r_d.state = ST_REGRD;
                    end else if (h[15:7] == OP_BX_COMP) begin
                        // Low three select bits plus the high-bank bit; 0..7 are shared storage
                        ctl_rd     = 1'b1;
                        ctl_rd_sel = {h[6], h[5:3]};
                        r_d.is_bx  = 1'b1;
                        r_d.state  = ST_REGRD;
                    end else begin
                        // No compact encoding reaches the status words
                        r_d.exec_valid = 1'b1;
                        r_d.iaddr      = r_q.pc;
                        r_d.pc         = r_q.pc + STEP_COMPACT;
                    end
                end else if (r_q.instr[27:4] == OP_BX_WIDE && cond_pass(r_q.instr[31:28], r_q.status)) begin
                    ctl_rd     = 1'b1;
                    ctl_rd_sel = r_q.instr[3:0];
                    r_d.is_bx  = 1'b1;
                    r_d.state  = ST_REGRD;
                end else begin
                    r_d.exec_valid = 1'b1;
                    r_d.iaddr      = r_q.pc;
                    r_d.pc         = r_q.pc + STEP_WIDE;
                end
            end
            ST_REGRD: begin
                r_d.state = ST_FETCH;
                if (r_q.is_bx) begin
                    r_d.status[STATE_FLAG_BIT] = rd_q[0];
                    r_d.pc = align_pc(rd_q, rd_q[0]);
                end else begin
                    tgt         = rd_q + scaled_ofs(h[10:0], 1'b1);
                    r_d.pc      = tgt;
                    ctl_wr      = 1'b1;
                    ctl_wr_data = (r_q.pc + STEP_COMPACT) | 32'h0000_0001;
                end
            end
            default: begin
                r_d.state = ST_FETCH;
            end
        endcase
        if (take_exc) begin
            ctl_wr      = 1'b1;
            ctl_wr_data = eaddr + link_ofs(kind, comp);
            r_d.saved   = r_q.status;
            r_d.status[STATE_FLAG_BIT] = 1'b0;
            r_d.pc      = VECTOR_BASE + VECTOR_STRIDE * ({29'h0, kind} + 32'h1);
            r_d.state   = ST_FETCH;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            r_q <= '{state:      ST_FETCH,
                     pc:         PC_RESET,
                     status:     STATUS_RESET,
                     saved:      STATUS_RESET,
                     instr:      32'h0000_0000,
                     iaddr:      PC_RESET,
                     is_bx:      1'b0,
                     exec_valid: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign fetch_req           = (r_q.state == ST_FETCH) && !exc_valid && !status_restore
                                 && !status_wr_en && !pc_wr_en;
    assign fetch_addr          = r_q.pc;
    assign fetch_compact       = r_q.status[STATE_FLAG_BIT];
    assign exec_valid          = r_q.exec_valid;
    assign exec_instr          = r_q.instr;
    assign exec_addr           = r_q.iaddr;
    assign exec_compact        = r_q.status[STATE_FLAG_BIT];
    // Compact: address plus 4 with bit 0 clear; wide: address plus 8
    assign pc_read_value       = r_q.status[STATE_FLAG_BIT]
                                 ? {(r_q.pc[31:1] + PC_RD_OFS_COMP[31:1]), 1'b0}
                                 : r_q.pc + PC_RD_OFS_WIDE;
    assign rf_wr_ready         = !ctl_wr;
    assign rf_rd_data          = rd_q;
    assign current_status_word = r_q.status;
    assign saved_status_word   = r_q.saved;
    assign compact_state       = r_q.status[STATE_FLAG_BIT];

endmodule

/* hdl/cisb_pkg.sv */
// Constants, encodings and types for the compact-state and branch control block
package cisb_pkg;

    // Status word layout and reset values
    localparam int          STATE_FLAG_BIT   = 5;
    localparam int          FLAG_N_BIT       = 31;
    localparam int          FLAG_Z_BIT       = 30;
    localparam int          FLAG_C_BIT       = 29;
    localparam int          FLAG_V_BIT       = 28;
    localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;
    localparam logic [31:0] PC_RESET         = 32'h0000_0000;

    // Program counter steps and read offsets
    localparam logic [31:0] STEP_WIDE        = 32'h0000_0004;
    localparam logic [31:0] STEP_COMPACT     = 32'h0000_0002;
    localparam logic [31:0] PC_RD_OFS_WIDE   = 32'h0000_0008;
    localparam logic [31:0] PC_RD_OFS_COMP   = 32'h0000_0004;

    // Link values and vector addresses on exception entry
    localparam logic [31:0] LR_OFS_2         = 32'h0000_0002;
    localparam logic [31:0] LR_OFS_4         = 32'h0000_0004;
    localparam logic [31:0] LR_OFS_8         = 32'h0000_0008;
    localparam logic [31:0] VECTOR_BASE      = 32'h0000_0000;
    localparam logic [31:0] VECTOR_STRIDE    = 32'h0000_0004;

    // Register file
    localparam int          REG_COUNT        = 16;
    localparam int          REG_SEL_W        = 4;
    localparam logic [3:0]  LINK_REG         = 4'he;

    // Compact branch encodings
    localparam logic [3:0]  OP_BCOND         = 4'hd;
    localparam logic [4:0]  OP_BUNC          = 5'h1c;
    localparam logic [4:0]  OP_BL_HIGH       = 5'h1e;
    localparam logic [4:0]  OP_BL_LOW        = 5'h1f;
    localparam logic [8:0]  OP_BX_COMP       = 9'h08e;
    localparam logic [3:0]  COND_UNDEF       = 4'he;
    localparam logic [3:0]  COND_TRAP        = 4'hf;
    localparam int          BL_HIGH_SHIFT    = 12;

    // Wide branch-exchange pattern, bits 27:4
    localparam logic [23:0] OP_BX_WIDE       = 24'h12fff1;

    typedef enum logic [2:0] {
        EXC_UNDEF,
        EXC_TRAP,
        EXC_PABORT,
        EXC_DABORT,
        EXC_IRQ,
        EXC_FIQ
    } cisb_exc_t;

    typedef enum logic [1:0] {
        ST_FETCH,
        ST_DECODE,
        ST_REGRD
    } cisb_state_t;

endpackage

/* hdl/cisb_regfile.sv */
// General register storage with one write port and one registered read port
module cisb_regfile #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int SEL_W = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             wr_en,
    input  wire logic [SEL_W-1:0] wr_sel,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [SEL_W-1:0] rd_sel,
    output logic      [WIDTH-1:0] rd_data_q
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_sel] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= mem[rd_sel];
        end
    end

endmodule

/* sim/cisb_ctrl_properties.sv */
// Port-level assertions for the compact-state control block
module cisb_ctrl_properties
    import cisb_pkg::*;
(
    input wire logic      ref_clk,
    input wire logic      nrst,
    input wire logic      fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic      exec_valid,
    input wire logic [31:0] exec_addr,
    input wire logic      exec_compact,
    input wire logic [31:0] pc_read_value,
    input wire logic      exc_valid,
    input wire cisb_exc_t exc_kind,
    input wire logic      exc_ack,
    input wire logic [31:0] current_status_word,
    input wire logic [31:0] saved_status_word,
    input wire logic      compact_state
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence exc_taken_s;
        exc_valid && exc_ack;
    endsequence
    vector_entry_a: assert property (exc_taken_s |=>
        fetch_addr == VECTOR_BASE + (32'($past(exc_kind)) + 32'h1) * VECTOR_STRIDE) else $error("bad vector");
    flag_saved_a: assert property (exc_taken_s |=>
        !compact_state && saved_status_word[STATE_FLAG_BIT] == $past(compact_state)) else $error("bad save");
    ack_cause_a: assert property (exc_ack |-> exc_valid && !fetch_req) else $error("stray ack");
    status_quiet_a: assert property ($changed(current_status_word) |-> !$past(fetch_req))
        else $error("status changed during fetch");
    pc_read_a: assert property (compact_state |->
        pc_read_value == ((fetch_addr + PC_RD_OFS_COMP) & 32'hffff_fffe)) else $error("bad pc read");
    pc_even_a: assert property (compact_state |-> !fetch_addr[0]) else $error("odd pc");
    pc_step_a: assert property (exec_valid |->
        fetch_addr == exec_addr + (exec_compact ? STEP_COMPACT : STEP_WIDE)) else $error("bad step");
    exec_gap_a: assert property (exec_valid |=> !exec_valid) else $error("exec too fast");
endmodule

/* sim/cisb_ctrl_test.sv */
// Self-checking bench for the compact-state control block
module cisb_ctrl_test
    import cisb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, nrst, fetch_req, fetch_compact, fetch_ack, exec_valid, exec_compact, exc_ack;
    logic        pc_wr_en, status_restore, status_wr_en, rf_wr_en, rf_wr_ready, exc_valid, compact_state;
    logic [31:0] fetch_addr, fetch_data, exec_instr, exec_addr, pc_read_value, pc_wr_data, status_wr_data;
    logic [31:0] rf_wr_data, rf_rd_data, exc_addr, current_status_word, saved_status_word;
    logic [3:0]  rf_wr_sel, rf_rd_sel;
    cisb_exc_t   exc_kind;
    int          delay, mismatches, check_count;
    cisb_ctrl u_cisb_ctrl (.ref_clk, .nrst, .fetch_req, .fetch_addr, .fetch_compact, .fetch_ack, .fetch_data,
        .exec_valid, .exec_instr, .exec_addr, .exec_compact, .pc_read_value, .pc_wr_en, .pc_wr_data,
        .status_restore, .status_wr_en, .status_wr_data, .rf_wr_en, .rf_wr_sel, .rf_wr_data, .rf_wr_ready,
        .rf_rd_sel, .rf_rd_data, .exc_valid, .exc_kind, .exc_addr, .exc_ack, .current_status_word,
        .saved_status_word, .compact_state);
    cisb_imem u_cisb_imem (.ref_clk, .nrst, .fetch_req, .fetch_addr, .delay, .fetch_ack, .fetch_data);
    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_for(input logic want, input logic cond_is_exec);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while ((cond_is_exec ? exec_valid : fetch_req) !== want && n < 200);
        if (n >= 200) begin
            mismatches++;
            report_and_stop();
        end
    endtask
    task automatic wait_exec(input logic [31:0] addr, input logic [31:0] instr, input logic cmp);
        wait_for(1'b1, 1'b1);
        check_val(exec_addr, addr);
        check_val(exec_instr, instr);
        check_val({31'h0, exec_compact}, {31'h0, cmp});
        check_val({31'h0, fetch_compact}, {31'h0, cmp});
    endtask
    // Side input presented for one cycle while the fetch is stalled
    task automatic side_in(input int sel, input logic [31:0] data, input cisb_exc_t kind);
        wait_for(1'b1, 1'b0);
        @(posedge ref_clk);
        {exc_valid, status_restore, status_wr_en, pc_wr_en} <= 4'h8 >> sel;
        {pc_wr_data, status_wr_data, exc_addr} <= {data, data, data};
        exc_kind <= kind;
        @(negedge ref_clk);
        check_val({31'h0, exc_ack}, {31'h0, sel == 0});
        check_val({31'h0, rf_wr_ready}, {31'h0, sel != 0});
        @(posedge ref_clk);
        {exc_valid, status_restore, status_wr_en, pc_wr_en} <= 4'h0;
        @(negedge ref_clk);
    endtask
    task automatic reg_access(input logic wr, input logic [3:0] sel, input logic [31:0] data);
        @(posedge ref_clk);
        {rf_wr_en, rf_wr_sel, rf_wr_data, rf_rd_sel} <= {wr, sel, data, sel};
        @(posedge ref_clk);
        rf_wr_en <= 1'b0;
        @(negedge ref_clk);
        if (!wr) check_val(rf_rd_data, data);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic test_branch_run();
        check_val(fetch_addr, PC_RESET);
        reg_access(1'b1, 4'h1, 32'h0000_0101);
        reg_access(1'b1, 4'h2, 32'h0000_0200);
        reg_access(1'b0, 4'h1, 32'h0000_0101);
        @(posedge ref_clk);
        delay <= 0;
        wait_exec(32'h0000_0100, 32'h0000_1c00, 1'b1);
        wait_exec(32'h0000_0122, 32'h0000_2000, 1'b1);
        wait_exec(32'h0000_0200, 32'he1a0_0000, 1'b0);
        @(posedge ref_clk);
        delay <= 1000;
        repeat (6) @(posedge ref_clk);
        check_val(fetch_addr, 32'h0000_0208);
        reg_access(1'b0, LINK_REG, 32'h0000_0113);
    endtask
    task automatic test_exceptions();
        logic [31:0] ofs [6] = '{LR_OFS_2, LR_OFS_2, LR_OFS_4, LR_OFS_8, LR_OFS_4, LR_OFS_4};
        side_in(2, 32'h0000_0020, EXC_UNDEF);
        for (int k = 0; k < 6; k++) begin
            side_in(0, 32'h0000_0300 + 32'(k * 16), cisb_exc_t'(k));
            check_val({31'h0, compact_state}, 32'h0);
            check_val({31'h0, saved_status_word[STATE_FLAG_BIT]}, 32'h1);
            check_val(fetch_addr, VECTOR_BASE + VECTOR_STRIDE * 32'(k + 1));
            reg_access(1'b0, LINK_REG, 32'h0000_0300 + 32'(k * 16) + ofs[k]);
            side_in(1, 32'h0, EXC_UNDEF);
            check_val({31'h0, compact_state}, 32'h1);
        end
    endtask
    task automatic test_pc_write();
        side_in(3, 32'h8000_0457, EXC_UNDEF);
        check_val(fetch_addr, 32'h8000_0456);
        check_val(pc_read_value, 32'h8000_045a);
    endtask
    // Compact trap fetched at the written pc, handler at its vector
    task automatic test_trap();
        @(posedge ref_clk);
        delay <= 0;
        wait_exec(32'h0000_0008, 32'h0000_0000, 1'b0);
        @(posedge ref_clk);
        delay <= 1000;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        check_val(fetch_addr, 32'h0000_0010);
        check_val({31'h0, saved_status_word[STATE_FLAG_BIT]}, 32'h1);
        reg_access(1'b0, LINK_REG, 32'h8000_0458);
    endtask
    initial begin
        {ref_clk, nrst, pc_wr_en, status_restore, status_wr_en, rf_wr_en, exc_valid} = 7'h0;
        {pc_wr_data, status_wr_data, rf_wr_data, exc_addr, rf_wr_sel, rf_rd_sel} = '0;
        exc_kind = EXC_UNDEF;
        {delay, mismatches, check_count} = {32'd1000, 32'd0, 32'd0};
        foreach (u_cisb_imem.mem[i]) u_cisb_imem.mem[i] = 32'h0;
        // Program: wide exchange, compact branches and call, compact exchange back
        u_cisb_imem.mem[8'h00] = 32'he12f_ff11;
        u_cisb_imem.mem[8'h40] = 32'hd005_1c00;
        u_cisb_imem.mem[8'h41] = 32'h0000_d102;
        u_cisb_imem.mem[8'h43] = 32'hf000_e7ff;
        u_cisb_imem.mem[8'h44] = 32'h0000_f808;
        u_cisb_imem.mem[8'h48] = 32'h2000_0000;
        u_cisb_imem.mem[8'h49] = 32'h0000_4710;
        u_cisb_imem.mem[8'h80] = 32'he1a0_0000;
        u_cisb_imem.mem[8'h81] = 32'he1a0_0000;
        u_cisb_imem.mem[8'h15] = 32'hdf00_0000;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        test_branch_run();
        test_exceptions();
        test_pc_write();
        test_trap();
        report_and_stop();
    end
endmodule
bind cisb_ctrl cisb_ctrl_properties u_cisb_ctrl_properties (.ref_clk, .nrst, .fetch_req, .fetch_addr, .exec_valid,
    .exec_addr, .exec_compact, .pc_read_value, .exc_valid, .exc_kind, .exc_ack, .current_status_word,
    .saved_status_word, .compact_state);

/* sim/cisb_imem.sv */
// Instruction memory model with programmable answer delay
module cisb_imem (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        fetch_req,
    input  wire logic [31:0] fetch_addr,
    input  wire integer      delay,
    output logic             fetch_ack,
    output logic [31:0]      fetch_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [256];
    int          wait_q;
    logic [31:0] last_q;
    assign fetch_ack = fetch_req && (wait_q >= delay);
    // Idle bus shows inverse of last word
    assign fetch_data = fetch_ack ? mem[fetch_addr[9:2]] : ~last_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 0;
            last_q <= 32'h0;
        end else begin
            wait_q <= (fetch_req && !fetch_ack) ? wait_q + 1 : 0;
            if (fetch_ack) begin
                last_q <= fetch_data;
            end
        end
    end
endmodule
